/* File: shared/cpu_ctrl_pkg.sv */
// Shared constants and types for the CPU control register bank.
package cpu_ctrl_pkg;
   // Register indices; the APB byte address is four times the index.
   localparam logic [5:0] IDX_GUARD = 6'h04;
   localparam logic [5:0] IDX_SP_LO = 6'h0D;
   localparam logic [5:0] IDX_SP_HI = 6'h0E;
   localparam logic [5:0] IDX_STATUS_FLAGS_REGISTER = 6'h0F;
   localparam int ADDR_W = 8;
   // Guard keys and status bits.
   localparam logic [7:0] KEY_SELF_PROG = 8'h9D;
   localparam logic [7:0] KEY_IO_UNLOCK = 8'hD8;
   localparam int GUARD_IO_BIT = 0;
   localparam int GUARD_SPM_BIT = 1;
   localparam logic [7:0] GUARD_RESET = 8'h00;
   // Status register bit positions and reset value.
   localparam int STATUS_FLAGS_REGISTER_I = 7;
   localparam int STATUS_FLAGS_REGISTER_T = 6;
   localparam int STATUS_FLAGS_REGISTER_H = 5;
   localparam int STATUS_FLAGS_REGISTER_S = 4;
   localparam int STATUS_FLAGS_REGISTER_V = 3;
   localparam int STATUS_FLAGS_REGISTER_N = 2;
   localparam int STATUS_FLAGS_REGISTER_Z = 1;
   localparam int STATUS_FLAGS_REGISTER_C = 0;
   localparam logic [7:0] STATUS_FLAGS_REGISTER_RESET = 8'h00;
   // Instruction count for the guard window and the stack write shield, and stack pointer steps.
   localparam logic [2:0] INSN_WINDOW = 3'h4;
   localparam logic [15:0] SP_CALL_STEP = 16'h0002;
   localparam logic [15:0] SP_BYTE_STEP = 16'h0001;

   typedef enum logic [2:0] {
      WIN_IDLE = 3'b001,
      WIN_IO = 3'b010,
      WIN_SPM = 3'b100
   } win_state_t;

   typedef struct packed {
      logic h_en;
      logic v_en;
      logic c_en;
      logic h;
      logic v;
      logic n;
      logic z;
      logic c;
   } alu_flags_t;

   typedef struct packed {
      logic insn_done;
      logic io_write;
      logic nvm_access;
      logic sleep_exec;
      logic interrupt_set_insn;
      logic interrupt_clear_insn;
      logic bit_store_to_flag;
      logic bst_val;
      logic alu_update;
      logic push1;
      logic pop1;
      logic push2;
      logic pop2;
   } core_evt_t;
endpackage

/* File: src/cpu_control_registers.sv */
// CPU control register bank: configuration guard, stack pointer and status register.
//
// Contract
// - Protected writes or instructions allowed only in four instructions after a valid key.
// - Key 0x9D opens self-programming, 0xD8 unlocks protected registers, others nothing.
// - No interrupt is serviced while a guard window is open; pending ones wait.
// - Guard bit 0 reads one while the register-unlock window is open.
// - Guard bit 1 reads one while the self-programming window is open.
// - Guard bits 7 to 2 always read zero.
// - Reset loads the stack pointer with the top SRAM address.
// - Only SRAM address bits of the stack pointer are writable; upper bits keep the top address value.
// - Stack pointer low byte at the base offset, high byte at the next.
// - Writing the stack low byte blocks interrupts four instructions or until an I/O write.
// - Status bit 7 is the global interrupt enable gating all interrupts.
// - Interrupt entry and return leave the global enable untouched.
// - Dedicated set and clear instructions and register writes change the global enable.
// - Changing the global enable over the register bus adds one wait cycle.
// - Status bit 6 is the bit-load source and bit-store destination.
// - Status bit 5 takes the half carry of supporting arithmetic operations.
// - Status bit 4 always equals negative xor overflow.
// - Status bit 3 takes signed overflow of supporting arithmetic operations.
// - Status bit 2 takes the negative result flag.
// - Status bit 1 takes the zero result flag.
// - Status bit 0 takes the carry flag.
// - The register-unlock window closes on I/O writes, NVM access or sleep.
// - Calls and interrupts lower the stack pointer by two, returns raise it by two.
`timescale 1ns/1ps
module cpu_control_registers #(
   parameter int SP_IMPL_BITS = 12,
   parameter logic [15:0] SP_TOP = 16'h7FFF
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cpu_ctrl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core events and ALU results.
   input wire cpu_ctrl_pkg::core_evt_t core_evt,
   input wire cpu_ctrl_pkg::alu_flags_t alu_flags,
   // State seen by the core.
   output logic irq_allow,
   output logic io_unlock_open,
   output logic self_prog_open,
   output logic [15:0] stack_pointer,
   output logic [7:0] status_flags,
   output logic t_bit
);
   import cpu_ctrl_pkg::*;

   localparam logic [15:0] SP_KEEP = 16'((32'h1 << SP_IMPL_BITS) - 32'h1);
   // The fixed upper bits copy the top address, so the pointer can never leave SRAM.
   localparam logic [15:0] SP_FIXED = SP_TOP & ~SP_KEEP;

   win_state_t win_q;
   logic [2:0] win_cnt_q;
   logic [2:0] shield_cnt_q;
   logic [15:0] sp_q;
   logic [15:0] sp_d;
   logic gie_q;
   logic t_q;
   logic h_q;
   logic v_q;
   logic n_q;
   logic z_q;
   logic c_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [5:0] idx;
   logic mapped;
   logic access;
   logic gie_change;
   logic commit;
   logic wr;
   logic [7:0] guard_rd;
   logic [7:0] status_flags_register_rd;

   assign idx = paddr[7:2];
   assign mapped = (paddr[1:0] == 2'h0) && (idx == IDX_GUARD || idx == IDX_SP_LO ||
      idx == IDX_SP_HI || idx == IDX_STATUS_FLAGS_REGISTER);
   assign access = psel & penable;
   assign gie_change = pwrite & mapped & (idx == IDX_STATUS_FLAGS_REGISTER) & (pwdata[STATUS_FLAGS_REGISTER_I] != gie_q);

   // A change of the global enable holds the access for exactly one extra cycle.
   assign pready = ~(access & gie_change & ~wait_q);
   assign commit = access & pready;
   assign wr = commit & pwrite & mapped;
   assign pslverr = commit & ~mapped;
   assign prdata = rdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= access & gie_change & ~wait_q;
      end
   end

   // Guard window: opened by a key, counted down by retired instructions.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_q <= WIN_IDLE;
         win_cnt_q <= 3'h0;
      end else if (wr && idx == IDX_GUARD && pwdata[7:0] == KEY_IO_UNLOCK) begin
         win_q <= WIN_IO;
         win_cnt_q <= INSN_WINDOW;
      end else if (wr && idx == IDX_GUARD && pwdata[7:0] == KEY_SELF_PROG) begin
         win_q <= WIN_SPM;
         win_cnt_q <= INSN_WINDOW;
      end else begin
         unique case (win_q)
            WIN_IDLE: begin
               win_cnt_q <= 3'h0;
            end
            WIN_IO: begin
               if (wr || core_evt.io_write || core_evt.nvm_access || core_evt.sleep_exec) begin
                  win_q <= WIN_IDLE;
                  win_cnt_q <= 3'h0;
               end else if (core_evt.insn_done) begin
                  win_cnt_q <= win_cnt_q - 3'h1;
                  if (win_cnt_q == 3'h1) begin
                     win_q <= WIN_IDLE;
                  end
               end
            end
            WIN_SPM: begin
               if (core_evt.nvm_access || core_evt.sleep_exec) begin
                  win_q <= WIN_IDLE;
                  win_cnt_q <= 3'h0;
               end else if (core_evt.insn_done) begin
                  win_cnt_q <= win_cnt_q - 3'h1;
                  if (win_cnt_q == 3'h1) begin
                     win_q <= WIN_IDLE;
                  end
               end
            end
            default: begin
               win_q <= WIN_IDLE;
               win_cnt_q <= 3'h0;
            end
         endcase
      end
   end

   assign io_unlock_open = (win_q == WIN_IO);
   assign self_prog_open = (win_q == WIN_SPM);

   // Shield after a stack low byte write, so the high byte can follow safely.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shield_cnt_q <= 3'h0;
      end else if (wr && idx == IDX_SP_LO) begin
         shield_cnt_q <= INSN_WINDOW;
      end else if (shield_cnt_q != 3'h0) begin
         if (wr || core_evt.io_write) begin
            shield_cnt_q <= 3'h0;
         end else if (core_evt.insn_done) begin
            shield_cnt_q <= shield_cnt_q - 3'h1;
         end
      end
   end

   // Pending interrupts are held off, not dropped; the core keeps them waiting.
   assign irq_allow = gie_q & (win_q == WIN_IDLE) & (shield_cnt_q == 3'h0);

   // Stack pointer; a bus write wins over a core push or pop in the same cycle.
   always_comb begin
      sp_d = sp_q;
      if (wr && idx == IDX_SP_LO) begin
         sp_d = {sp_q[15:8], pwdata[7:0]};
      end else if (wr && idx == IDX_SP_HI) begin
         sp_d = {pwdata[7:0], sp_q[7:0]};
      end else if (core_evt.push2) begin
         sp_d = sp_q - SP_CALL_STEP;
      end else if (core_evt.pop2) begin
         sp_d = sp_q + SP_CALL_STEP;
      end else if (core_evt.push1) begin
         sp_d = sp_q - SP_BYTE_STEP;
      end else if (core_evt.pop1) begin
         sp_d = sp_q + SP_BYTE_STEP;
      end
      sp_d = (sp_d & SP_KEEP) | SP_FIXED;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_q <= SP_TOP;
      end else begin
         sp_q <= sp_d;
      end
   end

   assign stack_pointer = sp_q;

   // Global enable; interrupt entry and return have no path here at all.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie_q <= STATUS_FLAGS_REGISTER_RESET[STATUS_FLAGS_REGISTER_I];
      end else if (wr && idx == IDX_STATUS_FLAGS_REGISTER) begin
         gie_q <= pwdata[STATUS_FLAGS_REGISTER_I];
      end else if (core_evt.interrupt_set_insn) begin
         gie_q <= 1'b1;
      end else if (core_evt.interrupt_clear_insn) begin
         gie_q <= 1'b0;
      end
   end

   // Arithmetic flags; the sign flag is never stored, only derived.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t_q <= STATUS_FLAGS_REGISTER_RESET[STATUS_FLAGS_REGISTER_T];
         h_q <= STATUS_FLAGS_REGISTER_RESET[STATUS_FLAGS_REGISTER_H];
         v_q <= STATUS_FLAGS_REGISTER_RESET[STATUS_FLAGS_REGISTER_V];
         n_q <= STATUS_FLAGS_REGISTER_RESET[STATUS_FLAGS_REGISTER_N];
         z_q <= STATUS_FLAGS_REGISTER_RESET[STATUS_FLAGS_REGISTER_Z];
         c_q <= STATUS_FLAGS_REGISTER_RESET[STATUS_FLAGS_REGISTER_C];
      end else if (wr && idx == IDX_STATUS_FLAGS_REGISTER) begin
         t_q <= pwdata[STATUS_FLAGS_REGISTER_T];
         h_q <= pwdata[STATUS_FLAGS_REGISTER_H];
         v_q <= pwdata[STATUS_FLAGS_REGISTER_V];
         n_q <= pwdata[STATUS_FLAGS_REGISTER_N];
         z_q <= pwdata[STATUS_FLAGS_REGISTER_Z];
         c_q <= pwdata[STATUS_FLAGS_REGISTER_C];
      end else begin
         if (core_evt.bit_store_to_flag) begin
            t_q <= core_evt.bst_val;
         end
         if (core_evt.alu_update) begin
            if (alu_flags.h_en) begin
               h_q <= alu_flags.h;
            end
            if (alu_flags.v_en) begin
               v_q <= alu_flags.v;
            end
            if (alu_flags.c_en) begin
               c_q <= alu_flags.c;
            end
            n_q <= alu_flags.n;
            z_q <= alu_flags.z;
         end
      end
   end

   assign status_flags_register_rd = {gie_q, t_q, h_q, n_q ^ v_q, v_q, n_q, z_q, c_q};
   assign status_flags = status_flags_register_rd;
   assign t_bit = t_q;
   assign guard_rd = {6'h00, self_prog_open, io_unlock_open};

   // Read data is latched in the setup cycle and stays put for the whole access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (psel && !penable) begin
         if (!mapped || pwrite) begin
            rdata_q <= 32'h0000_0000;
         end else if (idx == IDX_GUARD) begin
            rdata_q <= {24'h00_0000, guard_rd};
         end else if (idx == IDX_SP_LO) begin
            rdata_q <= {24'h00_0000, sp_q[7:0]};
         end else if (idx == IDX_SP_HI) begin
            rdata_q <= {24'h00_0000, sp_q[15:8]};
         end else begin
            rdata_q <= {24'h00_0000, status_flags_register_rd};
         end
      end
   end

   property p_key_opens;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_GUARD && pwdata[7:0] == KEY_IO_UNLOCK) |=>
         io_unlock_open && win_cnt_q == 3'h4;
   endproperty
   a_key_opens: assert property (p_key_opens)
      else $error("Unlock key did not open window");

   property p_bad_key;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_GUARD && pwdata[7:0] != KEY_IO_UNLOCK && pwdata[7:0] != KEY_SELF_PROG &&
         win_q == WIN_IDLE) |=> win_q == WIN_IDLE;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("Wrong key opened a window");

   property p_window_len;
      @(posedge pclk) disable iff (!presetn)
      (win_q != WIN_IDLE && win_cnt_q == 3'h1 && core_evt.insn_done && !wr) |=>
         win_q == WIN_IDLE;
   endproperty
   a_window_len: assert property (p_window_len)
      else $error("Window outlived four instructions");

   property p_no_irq_in_window;
      @(posedge pclk) disable iff (!presetn)
      (io_unlock_open || self_prog_open) |-> !irq_allow;
   endproperty
   a_no_irq_in_window: assert property (p_no_irq_in_window)
      else $error("Interrupt allowed in window");

   property p_io_close;
      @(posedge pclk) disable iff (!presetn)
      (io_unlock_open && (core_evt.io_write || core_evt.sleep_exec) && !wr) |=> !io_unlock_open;
   endproperty
   a_io_close: assert property (p_io_close) else $error("Unlock window stayed open");

   property p_guard_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && mapped && idx == IDX_GUARD) |=>
         prdata == {30'h0, $past(self_prog_open), $past(io_unlock_open)};
   endproperty
   a_guard_read: assert property (p_guard_read) else $error("Guard read value wrong");

   property p_sp_upper;
      @(posedge pclk) disable iff (!presetn)
      (stack_pointer & ~SP_KEEP) == SP_FIXED;
   endproperty
   a_sp_upper: assert property (p_sp_upper)
      else $error("Stack pointer fixed bits changed");

   property p_call_step;
      @(posedge pclk) disable iff (!presetn)
      (core_evt.push2 && !wr) |=>
         stack_pointer == ((($past(stack_pointer) - SP_CALL_STEP) & SP_KEEP) | SP_FIXED);
   endproperty
   a_call_step: assert property (p_call_step)
      else $error("Call did not lower pointer by two");

   property p_shield;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_SP_LO) |=> !irq_allow;
   endproperty
   a_shield: assert property (p_shield)
      else $error("Interrupt allowed after stack write");

   property p_gie_wait;
      @(posedge pclk) disable iff (!presetn)
      (access && !wait_q && gie_change) |-> !pready ##1 pready;
   endproperty
   a_gie_wait: assert property (p_gie_wait)
      else $error("Enable change had no single wait");

   property p_sign;
      @(posedge pclk) disable iff (!presetn)
      status_flags[STATUS_FLAGS_REGISTER_S] == (status_flags[STATUS_FLAGS_REGISTER_N] ^ status_flags[STATUS_FLAGS_REGISTER_V]);
   endproperty
   a_sign: assert property (p_sign) else $error("Sign flag is not N xor V");

   property p_gie_hold;
      @(posedge pclk) disable iff (!presetn)
      (!wr && !core_evt.interrupt_set_insn && !core_evt.interrupt_clear_insn) |=> status_flags[STATUS_FLAGS_REGISTER_I] == $past(status_flags[STATUS_FLAGS_REGISTER_I]);
   endproperty
   a_gie_hold: assert property (p_gie_hold)
      else $error("Global enable changed by itself");
endmodule

/* File: sim/cpu_control_registers_tb.sv */
// Self-checking testbench for the CPU control register bank.
`timescale 1ns/1ps
module cpu_control_registers_tb;
   import cpu_ctrl_pkg::*;
   localparam logic [12:0] E_INSN = 13'h1000;
   localparam logic [12:0] E_IOW = 13'h0800;
   localparam logic [12:0] E_NVM = 13'h0400;
   localparam logic [12:0] E_SLP = 13'h0200;
   localparam logic [12:0] E_SEI = 13'h0100;
   localparam logic [12:0] E_CLI = 13'h0080;
   localparam logic [12:0] E_BST = 13'h0060;
   localparam logic [12:0] E_ALU = 13'h0010;
   localparam logic [12:0] E_PUSH1 = 13'h0008;
   localparam logic [12:0] E_POP1 = 13'h0004;
   localparam logic [12:0] E_PUSH2 = 13'h0002;
   localparam logic [12:0] E_POP2 = 13'h0001;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   core_evt_t core_evt;
   alu_flags_t alu_flags;
   logic irq_allow, io_unlock_open, self_prog_open, t_bit;
   logic [15:0] stack_pointer;
   logic [7:0] status_flags;
   int fails = 0;
   int compares = 0;
   logic [7:0] r;
   logic e;
   int w;

   cpu_control_registers #(.SP_IMPL_BITS(12), .SP_TOP(16'h7FFF)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_evt(core_evt), .alu_flags(alu_flags), .irq_allow(irq_allow),
      .io_unlock_open(io_unlock_open), .self_prog_open(self_prog_open),
      .stack_pointer(stack_pointer), .status_flags(status_flags), .t_bit(t_bit));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic end_sim();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Pready is taken at the rising edge that ends the access; only the watchdog ends a wait.
   // The half cycle at the end lets callers look at outputs that have settled.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output int waits, output logic err);
      logic rdy;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      waits = 0;
      rdy = 1'b0;
      while (!rdy) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            rdy = 1'b1;
            rd = prdata[7:0];
            err = pslverr;
         end else begin
            waits++;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   task automatic alu(input logic [7:0] f);
      @(posedge pclk);
      alu_flags <= alu_flags_t'(f);
      evt(E_ALU, 1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, r, w, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00, r, w, e);
      chk(r, exp);
   endtask

   task automatic evt(input logic [12:0] v, input int n);
      repeat (n) begin
         @(posedge pclk);
         core_evt <= core_evt_t'(v);
         @(posedge pclk);
         core_evt <= core_evt_t'(13'h0000);
      end
      @(negedge pclk);
   endtask

   task automatic t_reset();
      chk(stack_pointer, 16'h7FFF);
      rd(8'h34, 8'hFF);
      rd(8'h38, 8'h7F);
      rd(8'h10, 8'h00);
      rd(8'h3C, 8'h00);
      chk(irq_allow, 1'b0);
   endtask

   task automatic t_guard();
      evt(E_SEI, 1);
      chk(status_flags, 8'h80);
      chk(irq_allow, 1'b1);
      wr(8'h10, KEY_IO_UNLOCK);
      rd(8'h10, 8'h01);
      chk(irq_allow, 1'b0);
      evt(E_INSN, 3);
      chk(io_unlock_open, 1'b1);
      evt(E_INSN, 1);
      chk(io_unlock_open, 1'b0);
      chk(irq_allow, 1'b1);
      wr(8'h10, KEY_SELF_PROG);
      rd(8'h10, 8'h02);
      evt(E_IOW, 1);
      chk(self_prog_open, 1'b1);
      evt(E_SLP, 1);
      chk(self_prog_open, 1'b0);
      wr(8'h10, KEY_SELF_PROG);
      evt(E_NVM, 1);
      chk(self_prog_open, 1'b0);
      wr(8'h10, KEY_IO_UNLOCK);
      evt(E_IOW, 1);
      chk(io_unlock_open, 1'b0);
      wr(8'h10, KEY_IO_UNLOCK);
      evt(E_NVM, 1);
      chk(io_unlock_open, 1'b0);
      wr(8'h10, 8'hFF);
      chk({io_unlock_open, self_prog_open}, 2'b00);
      rd(8'h10, 8'h00);
   endtask

   task automatic t_stack();
      wr(8'h38, 8'h12);
      wr(8'h34, 8'h34);
      @(negedge pclk);
      chk(stack_pointer, 16'h7234);
      chk(irq_allow, 1'b0);
      evt(E_INSN, 3);
      chk(irq_allow, 1'b0);
      evt(E_INSN, 1);
      chk(irq_allow, 1'b1);
      rd(8'h38, 8'h72);
      rd(8'h34, 8'h34);
      wr(8'h34, 8'h56);
      evt(E_IOW, 1);
      chk(irq_allow, 1'b1);
      evt(E_PUSH2, 1);
      chk(stack_pointer, 16'h7254);
      evt(E_POP2, 1);
      chk(stack_pointer, 16'h7256);
      evt(E_PUSH1, 1);
      chk(stack_pointer, 16'h7255);
      evt(E_POP1, 1);
      chk(stack_pointer, 16'h7256);
   endtask

   task automatic t_status();
      wr(8'h3C, 8'h00);
      chk(w, 1);
      chk(irq_allow, 1'b0);
      wr(8'h3C, 8'h00);
      chk(w, 0);
      wr(8'h3C, 8'h80);
      chk(w, 1);
      evt(E_CLI, 1);
      chk(status_flags, 8'h00);
      evt(E_SEI, 1);
      alu(8'hF5);
      chk(status_flags, 8'hB5);
      alu(8'hEE);
      chk(status_flags, 8'h8E);
      alu(8'h11);
      chk(status_flags, 8'h98);
      evt(E_BST, 1);
      chk(t_bit, 1'b1);
      chk(status_flags, 8'hD8);
      wr(8'h3C, 8'hD0);
      rd(8'h3C, 8'hC0);
   endtask

   // Refused accesses answer with an error and leave the registers alone.
   task automatic t_refused();
      apb(1'b0, 8'h00, 8'h00, r, w, e);
      chk({e, r}, 9'h100);
      apb(1'b1, 8'h11, 8'hD8, r, w, e);
      chk(e, 1'b1);
      chk(io_unlock_open, 1'b0);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h00000000;
      core_evt = core_evt_t'(13'h0000);
      alu_flags = alu_flags_t'(8'h00);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      t_reset();
      t_guard();
      t_stack();
      t_status();
      t_refused();
      end_sim();
   end

   // The whole run needs well under a thousand cycles; this bound only catches a hang.
   initial begin
      repeat (5000) @(posedge pclk);
      fails++;
      end_sim();
   end
endmodule
